// [nv_image_and_scan_sequencer.sv]
// What this block does
// - power-up copies program and data into RAM
// - read command accepted only while halted
// - write command accepted halted or running
// - word count 0..2048, else means 2048
// - halted write stores count words and the count
// - load restores stored count of words
// - alarm once command writes exceed 100,000
// - running-mode write saves program only
// - scan order diagnosis through peripheral support
// - init keeps forced bits and settings
// - init keeps retentive words, clears others
// - retentive range runs from zero upward
// - flag invalid retained data at power-up
// - unrecoverable diagnosis error enters error mode
// - floating scans restart immediately
// - fixed scans start every configured period
// - check program on entering running mode
// - IO update samples inputs, keeps forced bits
// - timer update advances timers and ticks
// - peripheral service limited per scan
// - priority bit lifts the peripheral limit
// - halted or error drives outputs off
`timescale 1ns/1ps
`default_nettype none
module nv_image_and_scan_sequencer
  import nv_seq_pkg::*;
#(
  parameter int PERIPH_CYC = PERIPH_LIMIT_CYC,
  parameter int STEP_CYC   = PERIOD_STEP_CYC,
  parameter int WEAR_MAX   = WEAR_LIMIT
)(
  input  wire logic        mclk,
  input  wire logic        resetn,
  output logic             hw_check_start,
  input  wire logic        hw_check_done,
  input  wire logic        hw_check_fail,
  output logic             diag_start,
  input  wire logic        diag_done,
  input  wire logic        diag_fatal,
  output logic             compile_start,
  input  wire logic        compile_done,
  input  wire logic        compile_ok,
  output logic             exec_start,
  input  wire logic        exec_done,
  output logic             timer_update,
  output logic             periph_grant,
  input  wire logic        periph_done,
  input  wire logic        mode_run_req,
  input  wire logic        error_reset,
  input  wire logic        cmd_nv_read,
  input  wire logic        cmd_nv_write,
  input  wire logic        fixed_scan,
  input  wire logic [4:0]  scan_period_code,
  input  wire logic        service_priority_bit,
  input  wire logic [15:0] saved_word_count,
  input  wire ret_cfg_t    retain_cfg,
  input  wire logic        retained_ok,
  output mem_req_t         ram_req,
  input  wire logic [15:0] ram_rdata,
  input  wire logic [15:0] force_rdata,
  output mem_req_t         nv_req,
  input  wire logic [15:0] nv_rdata,
  input  wire logic [15:0] in_pins,
  output logic [15:0]      out_pins,
  output logic [7:0]       timing_tick_bits,
  output logic             mode_run,
  output logic             mode_halt,
  output logic             mode_error,
  output logic             scan_start,
  output logic             cmd_busy,
  output logic             nv_wear_alarm_flag,
  output logic             retentive_invalid_flag
);

  typedef struct packed {
    phase_t      ph;
    mode_t       mode;
    logic        go;
    seg_t        seg;
    logic [2:0]  step;
    logic [12:0] idx;
    logic [11:0] len;
    logic        load;
    logic        boot;
    logic        save_all;
    logic        rd_pend;
    logic        wr_pend;
    logic        wear_inc;
    logic        ret_inv;
    logic [23:0] pcnt;
    mem_req_t    ram;
    mem_req_t    nv;
    logic [15:0] outq;
    logic [7:0]  ticks;
    logic [15:0] in_s1;
    logic [15:0] in_s2;
    logic [15:0] in_s3;
    logic [15:0] in_filt;
  } seq_st_t;

  seq_st_t     s;
  seq_st_t     n;
  logic        period_done;
  logic [7:0]  tick_now;
  logic [13:0] nxt;
  logic [13:0] seg_len;

  // Out-of-range counts save the full area.
  function automatic logic [11:0] eff_count(input logic [15:0] v);
    eff_count = (v > SAVE_MAX) ? SAVE_MAX[11:0] : v[11:0];
  endfunction

  function automatic logic [15:0] nv_addr_of(input seg_t sg, input logic [12:0] i);
    case (sg)
      SG_PROG: nv_addr_of = {3'h0, i};
      SG_CNT:  nv_addr_of = NV_COUNT_ADDR;
      default: nv_addr_of = NV_DATA_BASE + {3'h0, i};
    endcase
  endfunction

  function automatic logic [15:0] ram_addr_of(input seg_t sg, input logic [12:0] i);
    if (sg == SG_PROG)
    begin
      ram_addr_of = RAM_PROG_BASE + {3'h0, i};
    end
    else
    begin
      ram_addr_of = {3'h0, IMG_D + i};
    end
  endfunction

  // Start-up value of one image word; retentive ranges start at zero.
  function automatic logic [15:0] init_word(input logic [12:0] a, input logic [15:0] old,
                                            input logic [15:0] frc, input ret_cfg_t rc);
    logic [12:0] o;
    o = '0;
    init_word = '0;
    if (a < IMG_R)
    begin
      init_word = old & frc;
    end
    else if (a < IMG_S)
    begin
      o = a - IMG_R;
      init_word = (rc.en[0] && o <= {5'h00, rc.r}) ? old : (old & frc);
    end
    else if (a < IMG_T)
    begin
      o = a - IMG_S;
      init_word = SPECIAL_KEEP[o[5:0]] ? old : 16'h0000;
    end
    else if (a < IMG_C)
    begin
      o = a - IMG_T;
      init_word = (rc.en[1] && o <= {5'h00, rc.t}) ? old : 16'h0000;
    end
    else if (a < IMG_D)
    begin
      o = a - IMG_C;
      init_word = (rc.en[2] && o <= {5'h00, rc.c}) ? old : 16'h0000;
    end
    else if (a < IMG_IDX)
    begin
      o = a - IMG_D;
      init_word = (rc.en[3] && o <= {1'b0, rc.d}) ? old : 16'h0000;
    end
  endfunction

  nv_scan_timer #(
    .STEP_CYC    (STEP_CYC)
  ) u_timer (
    .mclk        (mclk),
    .resetn      (resetn),
    .scan_start  (scan_start),
    .period_code (scan_period_code),
    .period_done (period_done),
    .tick_bits   (tick_now)
  );

  nv_wear_counter #(
    .LIMIT  (WEAR_MAX)
  ) u_wear (
    .mclk   (mclk),
    .resetn (resetn),
    .inc    (s.wear_inc),
    .alarm  (nv_wear_alarm_flag)
  );

  assign nxt     = {1'b0, s.idx} + 14'h0001;
  assign seg_len = (s.seg == SG_PROG) ? PROG_WORDS : (s.seg == SG_CNT) ? 14'h0001 : {2'b00, s.len};

  // Next-state logic for the whole sequencer: one phase at a time.
  always_comb
  begin
    n = s;
    n.go = 1'b0;
    n.wear_inc = 1'b0;
    n.ram.we = 1'b0;
    n.nv.we = 1'b0;
    n.in_s1 = in_pins;
    n.in_s2 = s.in_s1;
    n.in_s3 = s.in_s2;
    n.in_filt = (s.in_s2 == s.in_s3) ? s.in_s3 : s.in_filt;
    n.rd_pend = s.rd_pend | cmd_nv_read;
    n.wr_pend = s.wr_pend | cmd_nv_write;
    case (s.ph)
      P_HWCHK:
      begin
        if (hw_check_done)
        begin
          n.ph = hw_check_fail ? P_ERROR : P_COPY;
          n.mode = hw_check_fail ? M_ERR : M_HALT;
          n.load = 1'b1;
          n.boot = 1'b1;
          n.seg = SG_PROG;
          n.idx = '0;
          n.step = '0;
        end
      end
      P_COPY:
      begin
        n.step = s.step + 3'h1;
        if (s.step == 3'h0)
        begin
          n.nv.addr = nv_addr_of(s.seg, s.idx);
          n.ram.addr = ram_addr_of(s.seg, s.idx);
        end
        else if (s.step == 3'h2)
        begin
          n.step = '0;
          n.idx = nxt[12:0];
          if (s.load && s.seg == SG_CNT)
          begin
            n.len = eff_count(nv_rdata);
          end
          else if (s.load)
          begin
            n.ram.we = 1'b1;
            n.ram.wdata = nv_rdata;
          end
          else
          begin
            n.nv.we = 1'b1;
            n.nv.wdata = (s.seg == SG_CNT) ? {4'h0, s.len} : ram_rdata;
          end
          if (nxt == seg_len)
          begin
            n.idx = '0;
            if (s.seg == SG_PROG && (s.load || s.save_all))
            begin
              n.seg = SG_CNT;
            end
            else if (s.seg == SG_CNT && n.len != 12'h000)
            begin
              n.seg = SG_DATA;
            end
            else
            begin
              n.ph = s.boot ? P_INIT : P_DIAG;
              n.go = 1'b1;
              n.wear_inc = !s.load;
              n.ret_inv = s.boot ? !retained_ok : s.ret_inv;
            end
          end
        end
      end
      P_INIT:
      begin
        n.step = s.step + 3'h1;
        if (s.step == 3'h0)
        begin
          n.ram.addr = {3'h0, s.idx};
        end
        else if (s.step == 3'h2)
        begin
          n.step = '0;
          n.idx = nxt[12:0];
          n.ram.we = 1'b1;
          n.ram.wdata = init_word(s.idx, ram_rdata, force_rdata, retain_cfg);
          if (nxt == IMG_WORDS)
          begin
            n.boot = 1'b0;
            n.ph = P_DIAG;
            n.go = 1'b1;
          end
        end
      end
      P_DIAG:
      begin
        if (diag_done)
        begin
          n.ph = diag_fatal ? P_ERROR : P_MODE;
          n.mode = diag_fatal ? M_ERR : s.mode;
          n.outq = diag_fatal ? 16'h0000 : s.outq;
        end
      end
      P_MODE:
      begin
        n.ph = P_IO;
        n.step = '0;
        n.seg = SG_PROG;
        n.idx = '0;
        if (s.rd_pend)
        begin
          n.rd_pend = cmd_nv_read;
          if (s.mode == M_HALT)
          begin
            n.ph = P_COPY;
            n.load = 1'b1;
          end
        end
        else if (s.wr_pend)
        begin
          n.wr_pend = cmd_nv_write;
          n.ph = P_COPY;
          n.load = 1'b0;
          n.save_all = (s.mode == M_HALT);
          n.len = eff_count(saved_word_count);
        end
        else if (s.mode == M_HALT && mode_run_req)
        begin
          n.ph = P_PCHK;
          n.go = 1'b1;
        end
        else if (s.mode == M_RUN && !mode_run_req)
        begin
          n.mode = M_HALT;
          n.outq = 16'h0000;
        end
      end
      P_PCHK:
      begin
        if (compile_done)
        begin
          n.ph = compile_ok ? P_IO : P_ERROR;
          n.mode = compile_ok ? M_RUN : M_ERR;
        end
      end
      P_IO:
      begin
        n.step = s.step + 3'h1;
        if (s.step == 3'h0)
        begin
          n.ram.addr = {3'h0, IMG_Y};
        end
        else if (s.step == 3'h2)
        begin
          n.outq = (s.mode == M_RUN) ? ram_rdata : 16'h0000;
          n.ram.addr = {3'h0, IMG_X};
        end
        else if (s.step == 3'h4)
        begin
          n.ram.we = 1'b1;
          n.ram.wdata = (ram_rdata & force_rdata) | (s.in_filt & ~force_rdata);
          n.ph = P_TIMER;
          n.go = 1'b1;
        end
      end
      P_TIMER:
      begin
        n.ticks = tick_now;
        n.ph = P_EXEC;
        n.go = 1'b1;
      end
      P_EXEC:
      begin
        if (s.mode != M_RUN || exec_done)
        begin
          n.ph = P_PERIPH;
          n.pcnt = '0;
        end
      end
      P_PERIPH:
      begin
        n.pcnt = s.pcnt + 24'h000001;
        if (periph_done || (!service_priority_bit && (fixed_scan ? period_done :
            s.pcnt == 24'(PERIPH_CYC - 1))))
        begin
          n.ph = fixed_scan ? P_WAIT : P_DIAG;
          n.go = !fixed_scan;
        end
      end
      P_WAIT:
      begin
        if (period_done)
        begin
          n.ph = P_DIAG;
          n.go = 1'b1;
        end
      end
      P_ERROR:
      begin
        n.outq = 16'h0000;
        if (error_reset)
        begin
          n.mode = M_HALT;
          n.ph = P_DIAG;
          n.go = 1'b1;
        end
      end
      default:
      begin
        n.ph = P_ERROR;
        n.mode = M_ERR;
      end
    endcase
  end

  // All sequencer state lives in one register.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.ph <= P_HWCHK;
      s.mode <= M_HALT;
      s.seg <= SG_PROG;
      s.go <= 1'b1;
      s.len <= SAVE_RESET[11:0];
    end
    else
    begin
      s <= n;
    end
  end

  // Start strobes are one-cycle pulses on phase entry.
  // The check strobe is held low in reset so no engine starts before release.
  assign hw_check_start   = resetn && s.go && s.ph == P_HWCHK;
  assign diag_start       = s.go && s.ph == P_DIAG;
  assign scan_start       = diag_start;
  assign compile_start    = s.go && s.ph == P_PCHK;
  assign timer_update     = s.go && s.ph == P_TIMER;
  assign exec_start       = s.go && s.ph == P_EXEC && s.mode == M_RUN;
  assign periph_grant     = s.ph == P_PERIPH;
  assign ram_req          = s.ram;
  assign nv_req           = s.nv;
  assign out_pins         = s.outq;
  assign timing_tick_bits = s.ticks;
  assign mode_run         = s.mode == M_RUN;
  assign mode_halt        = s.mode == M_HALT;
  assign mode_error       = s.mode == M_ERR;
  assign cmd_busy         = s.ph == P_COPY && !s.boot;
  assign retentive_invalid_flag = s.ret_inv;

  localparam int PLIM = PERIPH_CYC;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_io_end;
    s.ph == P_IO && s.step == 3'h4;
  endsequence
  sequence s_tail;
    s.ph == P_TIMER ##1 s.ph == P_EXEC;
  endsequence

  property p_boot_order;
    s.ph == P_HWCHK && hw_check_done && !hw_check_fail |=> s.ph == P_COPY && s.boot && s.load;
  endproperty
  a_boot_order: assert property (p_boot_order) else $error("boot order broken");

  property p_io_timer_exec;
    s_io_end |=> s_tail;
  endproperty
  a_io_timer_exec: assert property (p_io_timer_exec) else $error("scan order broken");

  property p_read_halt;
    s.ph == P_MODE && s.rd_pend && s.mode != M_HALT |=> s.ph != P_COPY;
  endproperty
  a_read_halt: assert property (p_read_halt) else $error("read accepted outside halt");

  property p_count_word;
    s.ph == P_COPY && !s.load && s.seg == SG_CNT && s.step == 3'h2
      |=> nv_req.we && nv_req.addr == NV_COUNT_ADDR && nv_req.wdata == {4'h0, $past(s.len)};
  endproperty
  a_count_word: assert property (p_count_word) else $error("count word not saved");

  property p_run_save;
    s.ph == P_COPY && !s.load && !s.save_all |-> s.seg == SG_PROG;
  endproperty
  a_run_save: assert property (p_run_save) else $error("running save touched data");

  property p_fatal;
    s.ph == P_DIAG && diag_done && diag_fatal |=> mode_error && s.ph == P_ERROR && out_pins == 16'h0000;
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal diagnosis ignored");

  property p_outputs_off;
    !mode_run |-> out_pins == 16'h0000;
  endproperty
  a_outputs_off: assert property (p_outputs_off) else $error("outputs on while stopped");

  property p_floating;
    s.ph == P_PERIPH && !fixed_scan && periph_done |=> s.ph == P_DIAG && scan_start;
  endproperty
  a_floating: assert property (p_floating) else $error("floating scan delayed");

  property p_periph_limit;
    s.ph == P_PERIPH && !fixed_scan && !service_priority_bit |-> s.pcnt < 24'(PLIM);
  endproperty
  a_periph_limit: assert property (p_periph_limit) else $error("peripheral time overrun");

  property p_force_keep;
    s_io_end |=> ram_req.we && ((ram_req.wdata ^ $past(ram_rdata)) & $past(force_rdata)) == 16'h0000;
  endproperty
  a_force_keep: assert property (p_force_keep) else $error("forced input overwritten");

endmodule
`default_nettype wire

// [nv_image_and_scan_sequencer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module nv_image_and_scan_sequencer_bench
  import nv_seq_pkg::*;
;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        run_req = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        fatal = 1'b0;
  logic        err_rst = 1'b0;
  logic [15:0] pins = 16'hC3C3;
  logic        fixed = 1'b0;
  logic        prio = 1'b0;
  logic        rok = 1'b0;
  logic [15:0] swc = 16'h0000;
  wire  [4:0]  starts;
  wire  [4:0]  dones;
  wire         m_run, m_halt, m_err, scan, busy, alarm, rinv;
  wire  [15:0] out_pins, ram_rdata, nv_rdata;
  mem_req_t    ram_req, nv_req;
  wire  [4:0]  flags = {m_err, m_run, m_halt, scan, busy};
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          t0 = 0;

  // D words 0 and 1 retentive; other image words are cleared at init, except the special setting words.
  localparam ret_cfg_t RCFG = '{en: 4'h8, r: 8'h00, t: 8'h00, c: 8'h00, d: 12'h001};

  always #25 mclk = ~mclk;

  // Edge counter used to time the scan period.
  always @(posedge mclk) cyc++;

  nv_image_and_scan_sequencer #(.PERIPH_CYC(20), .STEP_CYC(50), .WEAR_MAX(1)) i_nv_image_and_scan_sequencer (
    .mclk(mclk), .resetn(resetn), .hw_check_start(starts[0]), .hw_check_done(dones[0]),
    .hw_check_fail(1'b0), .diag_start(starts[1]), .diag_done(dones[1]), .diag_fatal(fatal),
    .compile_start(starts[2]), .compile_done(dones[2]), .compile_ok(1'b1), .exec_start(starts[3]),
    .exec_done(dones[3]), .timer_update(), .periph_grant(starts[4]), .periph_done(dones[4]),
    .mode_run_req(run_req), .error_reset(err_rst), .cmd_nv_read(rd), .cmd_nv_write(wr),
    .fixed_scan(fixed), .scan_period_code(5'h01), .service_priority_bit(prio),
    .saved_word_count(swc), .retain_cfg(RCFG), .retained_ok(rok), .ram_req(ram_req),
    .ram_rdata(ram_rdata), .force_rdata(16'h0000), .nv_req(nv_req), .nv_rdata(nv_rdata),
    .in_pins(pins), .out_pins(out_pins), .timing_tick_bits(), .mode_run(m_run), .mode_halt(m_halt),
    .mode_error(m_err), .scan_start(scan), .cmd_busy(busy), .nv_wear_alarm_flag(alarm),
    .retentive_invalid_flag(rinv));

  nv_partner i_nv_partner (.mclk(mclk), .starts(starts), .dones(dones), .ram_req(ram_req),
    .ram_rdata(ram_rdata), .nv_req(nv_req), .nv_rdata(nv_rdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait on the status flags, sampled just after each edge; a miss is a mismatch.
  task automatic await(input logic [4:0] mask, input logic [4:0] val);
    int k;
    k = 0;
    while (((flags & mask) !== val) && k < 60000)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k >= 60000)
      chk(16'(flags & mask), 16'(val));
  endtask

  task automatic pulse(ref logic s);
    @(posedge mclk);
    #1 s = 1'b1;
    @(posedge mclk);
    #1 s = 1'b0;
  endtask

  // A memory command runs to completion: busy rises, then falls, and the
  // last registered write lands in memory one edge later.
  task automatic nv_cmd(ref logic c);
    pulse(c);
    await(5'h01, 5'h01);
    await(5'h01, 5'h00);
    @(posedge mclk);
    #1;
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #4_900_000;
    n_errors++;
    print_verdict();
  end

  // Stored image: one program word, a count of three and four data words.
  initial
  begin
    i_nv_partner.nv[16'h0000] = 16'hA5A5;
    i_nv_partner.nv[16'h2000] = 16'h0003;
    for (int i = 0; i < 4; i++)
      i_nv_partner.nv[16'h2001 + i] = 16'h1111 * (i + 1);
    repeat (12) @(posedge mclk);
    #1 resetn = 1'b1;
    chk(16'(m_halt), 16'h0001);
    await(5'h02, 5'h02);
    chk(i_nv_partner.ram[16'h4000], 16'hA5A5);
    chk(i_nv_partner.ram[16'h0380], 16'h1111);
    chk(i_nv_partner.ram[16'h0381], 16'h2222);
    chk(i_nv_partner.ram[16'h0382], 16'h0000);
    chk(i_nv_partner.ram[16'h0383], 16'h0000);
    chk(16'(rinv), 16'h0001);
    chk(out_pins, 16'h0000);
    nv_cmd(wr);
    chk(i_nv_partner.nv[16'h2000], 16'h0000);
    chk(i_nv_partner.nv[16'h2001], 16'h1111);
    chk(16'(alarm), 16'h0000);
    run_req = 1'b1;
    await(5'h08, 5'h08);
    chk(16'(m_run), 16'h0001);
    i_nv_partner.ram[16'h4000] = 16'h1234;
    i_nv_partner.ram[16'h0380] = 16'h5555;
    pulse(rd);
    repeat (400) @(posedge mclk);
    chk(i_nv_partner.ram[16'h4000], 16'h1234);
    nv_cmd(wr);
    chk(i_nv_partner.nv[16'h0000], 16'h1234);
    chk(i_nv_partner.nv[16'h2001], 16'h1111);
    chk(16'(alarm), 16'h0001);
    // Fixed period with priority service: scans start one period apart.
    fixed = 1'b1;
    prio = 1'b1;
    await(5'h02, 5'h02);
    t0 = cyc;
    await(5'h02, 5'h00);
    await(5'h02, 5'h02);
    chk(16'(cyc - t0), 16'h0032);
    fatal = 1'b1;
    await(5'h10, 5'h10);
    chk(16'(m_err), 16'h0001);
    chk(out_pins, 16'h0000);
    fatal = 1'b0;
    run_req = 1'b0;
    pulse(err_rst);
    await(5'h04, 5'h04);
    chk(16'(m_halt), 16'h0001);
    print_verdict();
  end
endmodule
`default_nettype wire

// [nv_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module nv_partner
  import nv_seq_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic [4:0]  starts,
  output logic [4:0]       dones,
  input  wire mem_req_t    ram_req,
  output logic [15:0]      ram_rdata,
  input  wire mem_req_t    nv_req,
  output logic [15:0]      nv_rdata
);
  logic [15:0] ram [0:65535];
  logic [15:0] nv  [0:65535];
  logic [4:0]  d1 = 5'h00;
  logic [4:0]  d2 = 5'h00;

  // Engines answer three cycles late, so a done never shares its start's cycle.
  always_ff @(posedge mclk)
  begin
    d1 <= starts;
    d2 <= d1;
    dones <= d2;
  end

  // Both memories answer one edge after the address is registered, so the
  // sequencer sees the word in its third step. The bench preloads them too.
  always @(posedge mclk)
  begin
    ram_rdata <= ram[ram_req.addr];
    nv_rdata <= nv[nv_req.addr];
    if (ram_req.we)
      ram[ram_req.addr] <= ram_req.wdata;
    if (nv_req.we)
      nv[nv_req.addr] <= nv_req.wdata;
  end
endmodule
`default_nettype wire

// [nv_scan_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module nv_scan_timer
  import nv_seq_pkg::*;
#(
  parameter int STEP_CYC = PERIOD_STEP_CYC
)(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        scan_start,
  input  wire logic [4:0]  period_code,
  output logic             period_done,
  output logic [7:0]       tick_bits
);

  typedef struct packed {
    logic [23:0] free_cyc;
    logic [7:0]  ticks;
    logic [23:0] per_cyc;
    logic [4:0]  per_steps;
  } tmr_st_t;

  tmr_st_t    s;
  tmr_st_t    n;
  logic [4:0] code;

  // Out-of-range period settings are pinned to the nearest legal one.
  always_comb
  begin
    code = period_code;
    if (period_code < PERIOD_MIN_CODE)
    begin
      code = PERIOD_MIN_CODE;
    end
    else if (period_code > PERIOD_MAX_CODE)
    begin
      code = PERIOD_MAX_CODE;
    end
  end

  // Free step counter feeds the timing bits; the period counter restarts
  // with each scan so a fixed period is measured from scan start.
  // It restarts at two because the start strobe and the wait exit each cost a cycle.
  always_comb
  begin
    n = s;
    n.free_cyc = s.free_cyc + 24'h000001;
    if (s.free_cyc == 24'(STEP_CYC - 1))
    begin
      n.free_cyc = '0;
      n.ticks = s.ticks + 8'h01;
    end
    if (scan_start)
    begin
      n.per_cyc = 24'h000002;
      n.per_steps = '0;
    end
    else if (s.per_steps < code)
    begin
      n.per_cyc = s.per_cyc + 24'h000001;
      if (s.per_cyc == 24'(STEP_CYC - 1))
      begin
        n.per_cyc = '0;
        n.per_steps = s.per_steps + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign period_done = (s.per_steps >= code) && !scan_start;
  assign tick_bits   = s.ticks;

endmodule
`default_nettype wire

// [nv_seq_pkg.sv]
`default_nettype none
package nv_seq_pkg;

  // Clock rate and the timing figures derived from it.
  localparam int CLK_HZ           = 20_000_000;
  localparam int PERIPH_LIMIT_US  = 2000;
  localparam int PERIPH_LIMIT_CYC = PERIPH_LIMIT_US * (CLK_HZ / 1_000_000);
  localparam int PERIOD_STEP_MS   = 10;
  localparam int PERIOD_STEP_CYC  = PERIOD_STEP_MS * (CLK_HZ / 1000);
  localparam logic [4:0] PERIOD_MIN_CODE = 5'h01;
  localparam logic [4:0] PERIOD_MAX_CODE = 5'h14;
  localparam int WEAR_LIMIT       = 100_000;

  // Saved data word count limits.
  localparam logic [15:0] SAVE_MAX       = 16'h0800;
  localparam logic [15:0] SAVE_RESET     = 16'h0800;

  // Nonvolatile image layout.
  localparam logic [13:0] PROG_WORDS     = 14'h2000;
  localparam logic [15:0] NV_COUNT_ADDR  = 16'h2000;
  localparam logic [15:0] NV_DATA_BASE   = 16'h2001;

  // Working RAM layout: register images first, program above.
  localparam logic [15:0] RAM_PROG_BASE  = 16'h4000;
  localparam logic [12:0] IMG_X          = 13'h0000;
  localparam logic [12:0] IMG_Y          = 13'h0020;
  localparam logic [12:0] IMG_R          = 13'h0040;
  localparam logic [12:0] IMG_S          = 13'h0140;
  localparam logic [12:0] IMG_T          = 13'h0180;
  localparam logic [12:0] IMG_C          = 13'h0280;
  localparam logic [12:0] IMG_D          = 13'h0380;
  localparam logic [12:0] IMG_IDX        = 13'h1380;
  localparam logic [13:0] IMG_WORDS      = 14'h1383;
  // Special words that hold setting data and survive initialisation.
  localparam logic [63:0] SPECIAL_KEEP   = 64'h0380_0070_0000_0000;

  typedef enum logic [11:0] {
    P_HWCHK  = 12'h001,
    P_COPY   = 12'h002,
    P_INIT   = 12'h004,
    P_DIAG   = 12'h008,
    P_MODE   = 12'h010,
    P_PCHK   = 12'h020,
    P_IO     = 12'h040,
    P_TIMER  = 12'h080,
    P_EXEC   = 12'h100,
    P_PERIPH = 12'h200,
    P_WAIT   = 12'h400,
    P_ERROR  = 12'h800
  } phase_t;

  typedef enum logic [2:0] {
    M_HALT = 3'h1,
    M_RUN  = 3'h2,
    M_ERR  = 3'h4
  } mode_t;

  typedef enum logic [2:0] {
    SG_PROG = 3'h1,
    SG_CNT  = 3'h2,
    SG_DATA = 3'h4
  } seg_t;

  typedef struct packed {
    logic [3:0]  en;
    logic [7:0]  r;
    logic [7:0]  t;
    logic [7:0]  c;
    logic [11:0] d;
  } ret_cfg_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        we;
    logic [15:0] wdata;
  } mem_req_t;

endpackage
`default_nettype wire

// [nv_wear_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module nv_wear_counter
  import nv_seq_pkg::*;
#(
  parameter int LIMIT = WEAR_LIMIT
)(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        inc,
  output logic             alarm
);

  typedef struct packed {
    logic [16:0] cnt;
    logic        alarm;
  } wear_st_t;

  wear_st_t s;
  wear_st_t n;

  // Saturating count; the alarm sticks once the count passes the limit.
  always_comb
  begin
    n = s;
    if (inc && s.cnt != 17'h1FFFF)
    begin
      n.cnt = s.cnt + 17'h00001;
    end
    n.alarm = s.alarm | (n.cnt > 17'(LIMIT));
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign alarm = s.alarm;

  property p_wear_alarm;
    @(posedge mclk) disable iff (!resetn)
    inc && s.cnt == 17'(LIMIT) |=> alarm;
  endproperty
  a_wear_alarm: assert property (p_wear_alarm) else $error("wear alarm missed");

  property p_wear_hold;
    @(posedge mclk) disable iff (!resetn)
    !inc |=> $stable(s.cnt);
  endproperty
  a_wear_hold: assert property (p_wear_hold) else $error("wear count moved");

endmodule
`default_nettype wire
